// File: gpio3_port.sv
/*
  Three-pin general-purpose port with alternate functions, AXI4-Lite slave.
  Assumes pins arrive asynchronously; peripheral signals share aclk.
*/
// Added by the designer: the AXI4-Lite register port.
`include "gpio3_map.svh"
`timescale 1ns/10ps
`default_nettype none

module gpio3_port (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire gpio3_pkg::pin_vec_t   pin_in,
  output gpio3_pkg::pin_vec_t        pin_out,
  output gpio3_pkg::pin_vec_t        pin_oe,
  output gpio3_pkg::pin_vec_t        pin_pullup,
  output gpio3_pkg::pin_vec_t        pin_input_en,
  input  wire gpio3_pkg::alt_drive_s alt_drive,
  output gpio3_pkg::alt_sense_s      alt_sense
);

  gpio3_pkg::state_s   s;
  gpio3_pkg::state_s   next_s;
  gpio3_pkg::pin_vec_t alt_sel;
  gpio3_pkg::pin_vec_t alt_val;
  gpio3_pkg::pin_vec_t alt_drives;
  gpio3_pkg::pin_vec_t raw_out;
  gpio3_pkg::pin_vec_t sensed;
  gpio3_pkg::pin_vec_t fs1_val;
  gpio3_pkg::pin_vec_t fs1_drv;
  gpio3_pkg::pin_vec_t fs3_val;
  logic                aw_take;
  logic                w_take;
  logic                ar_take;
  logic                do_wr;
  logic                ar_hit;
  logic [5:0]          ar_off;

  function automatic logic offset_mapped(input logic [5:0] off);
    case (off)
      `GP_OFF_DATA, `GP_OFF_OE, `GP_OFF_FS1, `GP_OFF_FS2, `GP_OFF_FS3,
      `GP_OFF_FS4, `GP_OFF_OD, `GP_OFF_PUP, `GP_OFF_IE: offset_mapped = 1'b1;
      default: offset_mapped = 1'b0;
    endcase
  endfunction : offset_mapped

  function automatic gpio3_pkg::pin_vec_t read_reg(input gpio3_pkg::port_regs_s r,
                                                   input gpio3_pkg::pin_vec_t   pins,
                                                   input logic [5:0]            off);
    case (off)
      `GP_OFF_DATA: read_reg = (r.ie & pins) | (~r.ie & r.data);
      `GP_OFF_OE:   read_reg = r.oe;
      `GP_OFF_FS1:  read_reg = r.fs1;
      `GP_OFF_FS2:  read_reg = r.fs2;
      `GP_OFF_FS3:  read_reg = r.fs3;
      `GP_OFF_FS4:  read_reg = r.fs4;
      `GP_OFF_OD:   read_reg = r.od;
      `GP_OFF_PUP:  read_reg = r.pup;
      `GP_OFF_IE:   read_reg = r.ie;
      default:      read_reg = 3'h0;
    endcase
  endfunction : read_reg

  // Bus handshakes; one write and one read in flight
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign do_wr         = s.aw_got && s.w_got && !s.bvalid;
  assign ar_hit        = (s_axi_araddr[31:6] == 26'(`GP_BASE_ADDR >> 6)) &&
                         offset_mapped(s_axi_araddr[5:0]);
  assign ar_off        = s_axi_araddr[5:0];

  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  // Per-function pin tables, bit index is the pin number
  assign fs1_val = {alt_drive.serial_ch1_clock_out, 1'b0, alt_drive.serial_ch1_transmit};
  assign fs1_drv = {alt_drive.serial_ch1_clock_oe, 1'b0, 1'b1};
  assign fs3_val = {alt_drive.timer0_output, 2'b00};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_pin
      assign alt_sel[i] = s.r.fs1[i] | s.r.fs2[i] | s.r.fs3[i] | s.r.fs4[i];
      // Fixed priority keeps a doubly selected pin defined
      assign alt_val[i] = s.r.fs1[i] ? fs1_val[i] :
                          s.r.fs2[i] ? alt_drive.ext_address[2 - i] :
                          s.r.fs3[i] ? fs3_val[i] : 1'b0;
      assign alt_drives[i] = s.r.fs1[i] ? fs1_drv[i] :
                             s.r.fs2[i] ? 1'b1 :
                             s.r.fs3[i] ? (i == 2) : 1'b0;
      assign raw_out[i] = alt_sel[i] ? alt_val[i] : s.r.data[i];
      // Open drain only ever pulls low
      assign pin_out[i] = s.r.od[i] ? 1'b0 : raw_out[i];
      assign pin_oe[i]  = s.r.oe[i] && (!alt_sel[i] || alt_drives[i]) &&
                          (!s.r.od[i] || !raw_out[i]);
    end
  endgenerate

  assign pin_pullup   = s.r.pup;
  assign pin_input_en = s.r.ie;
  assign sensed       = s.sync2 & s.r.ie;

  assign alt_sense.serial_ch1_clock         = s.r.fs1[2] & sensed[2];
  assign alt_sense.serial_ch1_receive       = s.r.fs1[1] ? sensed[1] : 1'b1;
  assign alt_sense.serial_ch1_clear_to_send = s.r.fs4[2] & sensed[2];
  assign alt_sense.timer2_capture_input1    = s.r.fs3[1] & sensed[1];
  assign alt_sense.timer2_capture_input0    = s.r.fs3[0] & sensed[0];

  always_comb begin
    next_s       = s;
    next_s.sync1 = pin_in;
    next_s.sync2 = s.sync1;
    if (aw_take) begin
      next_s.aw_got = 1'b1;
      next_s.aw_hit = (s_axi_awaddr[31:6] == 26'(`GP_BASE_ADDR >> 6)) &&
                      offset_mapped(s_axi_awaddr[5:0]);
      next_s.aw_off = s_axi_awaddr[5:0];
    end
    if (w_take) begin
      next_s.w_got  = 1'b1;
      next_s.wbits  = s_axi_wdata[2:0];
      next_s.wlane0 = s_axi_wstrb[0];
    end
    if (do_wr) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = s.aw_hit ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
      if (s.aw_hit && s.wlane0) begin
        case (s.aw_off)
          `GP_OFF_DATA: next_s.r.data = s.wbits;
          `GP_OFF_OE:   next_s.r.oe   = s.wbits;
          `GP_OFF_FS1:  next_s.r.fs1  = s.wbits;
          `GP_OFF_FS2:  next_s.r.fs2  = s.wbits;
          `GP_OFF_FS3:  next_s.r.fs3  = s.wbits;
          `GP_OFF_FS4:  next_s.r.fs4  = s.wbits & `GP_FS4_MASK;
          `GP_OFF_OD:   next_s.r.od   = s.wbits;
          `GP_OFF_PUP:  next_s.r.pup  = s.wbits;
          `GP_OFF_IE:   next_s.r.ie   = s.wbits;
          default:      next_s.r      = s.r;
        endcase
      end
    end else if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = {29'h0, ar_hit ? read_reg(s.r, s.sync2, ar_off) : 3'h0};
      next_s.rresp  = ar_hit ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s      <= '0;
      s.r.oe <= `GP_RESET_PINS;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_reset_idle: assert property ($past(!aresetn) |->
      pin_oe == 3'h0 && pin_pullup == 3'h0 && pin_input_en == 3'h0)
    else $error("pins not idle after reset");
  chk_plain_drive: assert property ((s.r.fs1 | s.r.fs2 | s.r.fs3 | s.r.fs4) == 3'h0 &&
      s.r.od == 3'h0 |-> pin_out == s.r.data && pin_oe == s.r.oe)
    else $error("plain pin not driven from data");
  chk_od_no_high: assert property ((pin_oe & s.r.od & raw_out) == 3'h0)
    else $error("open drain pin driven high");
  chk_data_write: assert property (do_wr && s.aw_hit && s.wlane0 &&
      s.aw_off == `GP_OFF_DATA |=> s.r.data == $past(s.wbits) && s_axi_bvalid)
    else $error("data write lost");
  chk_oe_write: assert property (do_wr && s.aw_hit && s.wlane0 &&
      s.aw_off == `GP_OFF_OE |=> s.r.oe == $past(s.wbits))
    else $error("output enable write lost");
  chk_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:3] == 29'h0)
    else $error("upper read bits not zero");
  chk_read_answer: assert property (ar_take |=> s_axi_rvalid [*1] ##0
      s_axi_rresp == ($past(ar_hit) ? `GP_RESP_OKAY : `GP_RESP_SLVERR))
    else $error("read answer late or wrong");
  chk_serial_tx: assert property (s.r.fs1[0] && s.r.oe[0] && !s.r.od[0] |->
      pin_out[0] == alt_drive.serial_ch1_transmit && pin_oe[0])
    else $error("transmit not routed to pin 0");
  chk_addr_route: assert property (s.r.fs2 == 3'h7 && s.r.fs1 == 3'h0 && s.r.od == 3'h0 |->
      pin_out == {alt_drive.ext_address[0], alt_drive.ext_address[1],
                  alt_drive.ext_address[2]})
    else $error("address bits misrouted");
  chk_capture_in: assert property (s.r.fs3[0] |->
      alt_sense.timer2_capture_input0 == (s.sync2[0] & s.r.ie[0]))
    else $error("capture input misrouted");
  chk_fs4_low: assert property (s.r.fs4[1:0] == 2'h0)
    else $error("select 4 low bits set");
  chk_pullup_write: assert property (do_wr && s.aw_hit && s.wlane0 &&
      s.aw_off == `GP_OFF_PUP |=> pin_pullup == $past(s.wbits))
    else $error("pull-up write lost");

  cov_write_resp: cover property (s_axi_bvalid && s_axi_bready);
  cov_read_pin:   cover property (ar_take && ar_off == `GP_OFF_DATA && s.r.ie != 3'h0);
  cov_unmapped:   cover property (s_axi_bvalid && s_axi_bresp == `GP_RESP_SLVERR);
  cov_od_release: cover property (s.r.od[0] && s.r.oe[0] && !pin_oe[0]);

endmodule : gpio3_port

`default_nettype wire

// File: gpio3_map.svh
/*
  Register offsets, reset values and bus codes of the three-pin port.
  Assumes the AXI4-Lite interconnect presents full byte addresses.
*/
`ifndef GPIO3_MAP_SVH
`define GPIO3_MAP_SVH

`define GP_BASE_ADDR     32'h400C_0200
`define GP_OFF_DATA      6'h00
`define GP_OFF_OE        6'h04
`define GP_OFF_FS1       6'h08
`define GP_OFF_FS2       6'h0C
`define GP_OFF_FS3       6'h10
`define GP_OFF_FS4       6'h14
`define GP_OFF_OD        6'h28
`define GP_OFF_PUP       6'h2C
`define GP_OFF_IE        6'h38
`define GP_RESET_PINS    3'h0
`define GP_FS4_MASK      3'h4
`define GP_RESP_OKAY     2'h0
`define GP_RESP_SLVERR   2'h2

`endif

// File: gpio3_pkg.sv
/*
  Types of the three-pin port: register set, alternate-function carriers
  and the single state record of the port module.
  Assumes gpio3_map.svh supplies the numeric constants.
*/
`default_nettype none

package gpio3_pkg;

  typedef logic [2:0] pin_vec_t;

  typedef struct packed {
    pin_vec_t data;
    pin_vec_t oe;
    pin_vec_t fs1;
    pin_vec_t fs2;
    pin_vec_t fs3;
    pin_vec_t fs4;
    pin_vec_t od;
    pin_vec_t pup;
    pin_vec_t ie;
  } port_regs_s;

  // Signals from the peripherals into the port
  typedef struct packed {
    logic     serial_ch1_clock_out;
    logic     serial_ch1_clock_oe;
    logic     serial_ch1_transmit;
    logic     timer0_output;
    pin_vec_t ext_address;
  } alt_drive_s;

  // Signals from the port to the peripherals
  typedef struct packed {
    logic serial_ch1_clock;
    logic serial_ch1_receive;
    logic serial_ch1_clear_to_send;
    logic timer2_capture_input1;
    logic timer2_capture_input0;
  } alt_sense_s;

  typedef struct packed {
    port_regs_s  r;
    pin_vec_t    sync1;
    pin_vec_t    sync2;
    logic        aw_got;
    logic        w_got;
    logic        aw_hit;
    logic [5:0]  aw_off;
    pin_vec_t    wbits;
    logic        wlane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_s;

endpackage : gpio3_pkg

`default_nettype wire

// File: gpio3_board.sv
/*
  Board circuitry on the three port pins: pad driver, pull-up, an external
  source and a floating level that changes every cycle.
  Assumes the port's pad outputs and a bench-driven external source.
*/
`timescale 1ns/10ps
`default_nettype none

module gpio3_board (
  input  wire logic                aclk,
  input  wire gpio3_pkg::pin_vec_t pin_out,
  input  wire gpio3_pkg::pin_vec_t pin_oe,
  input  wire gpio3_pkg::pin_vec_t pin_pullup,
  input  wire gpio3_pkg::pin_vec_t ext_val,
  input  wire gpio3_pkg::pin_vec_t ext_en,
  output var  gpio3_pkg::pin_vec_t pin_in
);
  gpio3_pkg::pin_vec_t noise = 3'h5;

  // Undriven pins wander so a stale value never passes
  always @(posedge aclk) begin
    noise <= ~noise;
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = noise[i];
    end
  end
endmodule : gpio3_board

`default_nettype wire

// File: three_bit_port_with_alt_func_test.sv
/*
  Self-checking bench of the three-pin port driven over AXI4-Lite.
  Assumes gpio3_board resolves the pads and the map header gives offsets.
*/
`include "gpio3_map.svh"
`timescale 1ns/10ps
`default_nettype none

module three_bit_port_with_alt_func_test;
  logic                  aclk = 1'b0;
  logic                  aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic                  s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0]           s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  gpio3_pkg::pin_vec_t   pin_in, pin_out, pin_oe, pin_pullup, pin_input_en, ext_val, ext_en;
  gpio3_pkg::alt_drive_s alt_drive;
  gpio3_pkg::alt_sense_s alt_sense;
  int                    miscompares = 0, total_checks = 0, cycles = 0;
  // Only mapped offsets are sent inside the window
  logic [5:0]            offs [9] = '{`GP_OFF_DATA, `GP_OFF_OE, `GP_OFF_FS1, `GP_OFF_FS2,
                                      `GP_OFF_FS3, `GP_OFF_FS4, `GP_OFF_OD, `GP_OFF_PUP, `GP_OFF_IE};

  gpio3_port DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_input_en, .alt_drive, .alt_sense);
  gpio3_board board (.aclk, .pin_out, .pin_oe, .pin_pullup, .ext_val, .ext_en, .pin_in);

  always #10 aclk = ~aclk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Entered just after a rising edge; readiness is read before the next one
  task automatic axi_wr(input logic [7:0] off, input logic [31:0] d, input logic [1:0] er);
    logic       a, w, b;
    logic [1:0] r;
    b = 1'b0;
    s_axi_awaddr <= `GP_BASE_ADDR | 32'(off);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      a = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    check(32'(r), 32'(er));
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] off, input logic [1:0] er, input logic [31:0] ed);
    logic        a, b;
    logic [31:0] d;
    logic [1:0]  r;
    b = 1'b0;
    s_axi_araddr <= `GP_BASE_ADDR | 32'(off);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      a = s_axi_arvalid & s_axi_arready;
      b = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
    end
    check(32'(r), 32'(er));
    check(d, ed);
  endtask : axi_rd

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    ext_val = 3'h5;
    ext_en = 3'h0;
    alt_drive = '{1'b0, 1'b1, 1'b1, 1'b1, 3'h1};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (offs[i]) axi_rd(offs[i], `GP_RESP_OKAY, 32'h0);
    check(32'({pin_oe, pin_pullup, pin_input_en}), 32'h0);
    axi_rd(8'h40, `GP_RESP_SLVERR, 32'h0);
    axi_wr(8'h44, 32'h7, `GP_RESP_SLVERR);
    $display("test reset and map done");
    // One register set at a time
    foreach (offs[i]) begin
      axi_wr(offs[i], 32'hFFFF_FFFF, `GP_RESP_OKAY);
      axi_rd(offs[i], `GP_RESP_OKAY, (offs[i] == `GP_OFF_FS4) ? 32'h4 : 32'h7);
      axi_wr(offs[i], 32'h0, `GP_RESP_OKAY);
    end
    $display("test register bits done");
    axi_wr(`GP_OFF_OE, 32'h7, `GP_RESP_OKAY);
    axi_wr(`GP_OFF_DATA, 32'h5, `GP_RESP_OKAY);
    check(32'({pin_oe, pin_out}), 32'h3D);
    axi_wr(`GP_OFF_OD, 32'h5, `GP_RESP_OKAY);
    check(32'({pin_oe, pin_out}), 32'h10);
    axi_wr(`GP_OFF_DATA, 32'h0, `GP_RESP_OKAY);
    check(32'({pin_oe, pin_out}), 32'h38);
    axi_wr(`GP_OFF_OD, 32'h0, `GP_RESP_OKAY);
    axi_wr(`GP_OFF_OE, 32'h0, `GP_RESP_OKAY);
    ext_en <= 3'h7;
    axi_wr(`GP_OFF_IE, 32'h7, `GP_RESP_OKAY);
    repeat (3) @(posedge aclk);
    axi_rd(`GP_OFF_DATA, `GP_RESP_OKAY, 32'h5);
    ext_en <= 3'h0;
    axi_wr(`GP_OFF_PUP, 32'h7, `GP_RESP_OKAY);
    repeat (3) @(posedge aclk);
    axi_rd(`GP_OFF_DATA, `GP_RESP_OKAY, 32'h7);
    check(32'({pin_pullup, pin_input_en}), 32'h3F);
    $display("test plain pins done");
    ext_en <= 3'h7;
    axi_wr(`GP_OFF_PUP, 32'h0, `GP_RESP_OKAY);
    axi_wr(`GP_OFF_OE, 32'h7, `GP_RESP_OKAY);
    axi_wr(`GP_OFF_FS1, 32'h7, `GP_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(32'({pin_oe, pin_out & 3'h5, alt_sense.serial_ch1_receive}), 32'h52);
    // Serial clock released to the board source
    alt_drive.serial_ch1_clock_oe <= 1'b0;
    repeat (3) @(posedge aclk);
    check(32'({pin_oe, alt_sense.serial_ch1_clock}), 32'h3);
    axi_wr(`GP_OFF_FS1, 32'h0, `GP_RESP_OKAY);
    axi_wr(`GP_OFF_FS2, 32'h7, `GP_RESP_OKAY);
    check(32'({pin_oe, pin_out}), 32'h3C);
    axi_wr(`GP_OFF_FS2, 32'h0, `GP_RESP_OKAY);
    axi_wr(`GP_OFF_FS3, 32'h7, `GP_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(32'({pin_oe, pin_out[2], alt_sense.timer2_capture_input1,
               alt_sense.timer2_capture_input0}), 32'h25);
    axi_wr(`GP_OFF_FS3, 32'h0, `GP_RESP_OKAY);
    axi_wr(`GP_OFF_FS4, 32'h7, `GP_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(32'({pin_oe, alt_sense.serial_ch1_clear_to_send}), 32'h7);
    axi_wr(`GP_OFF_FS4, 32'h0, `GP_RESP_OKAY);
    check(32'(pin_out & 3'h5), 32'h0);
    $display("test alternate functions done");
    give_verdict();
  end
endmodule : three_bit_port_with_alt_func_test

`default_nettype wire
